// ===== core/sfpi_pkg.sv
// holds the shared constants of the serial flash pin interface
// assumes one 100 MHz system clock that samples every pin

package sfpi_pkg;

	// ****************************************************
	// register map of the local control port
	// ****************************************************
	localparam logic [3:0] REG_CONFIG = 4'h0; // quad setting and protect field
	localparam logic [3:0] REG_STATUS = 4'h1; // live pin-interface state

	// ****************************************************
	// field positions and reset values
	// ****************************************************
	localparam int         CFG_QUAD_BIT = 0;     // quad pin-out enable
	localparam int         CFG_BP_LSB   = 1;     // block protect field low bit
	localparam int         BP_W         = 3;     // block protect field width
	localparam logic [7:0] CFG_RESET    = 8'h00; // config after reset
	localparam int         ST_ARMED     = 0;     // first select seen
	localparam int         ST_SELECTED  = 1;     // device selected
	localparam int         ST_ACTIVE    = 2;     // active power state
	localparam int         ST_PAUSED    = 3;     // pause in force
	localparam int         ST_WP        = 4;     // write protect in force

	// ****************************************************
	// pin count and synchroniser depth
	// ****************************************************
	localparam int SYNC_STAGES = 2; // flops before any logic reads a pin
	localparam int PIN_COUNT   = 6; // sampled pins

	// ****************************************************
	// lane widths and link states
	// ****************************************************
	typedef enum logic [1:0] {
		SFPI_W1 = 2'b00, // one lane
		SFPI_W2 = 2'b01, // two lanes
		SFPI_W4 = 2'b10  // four lanes
	} sfpi_width_e;

	typedef enum logic [1:0] {
		LS_IDLE   = 2'b00, // deselected
		LS_ACTIVE = 2'b01, // selected and shifting
		LS_PAUSE  = 2'b10  // selected but paused
	} sfpi_link_e;

endpackage : sfpi_pkg

// ===== core/sfpi_sync.sv
// holds a plain two-flop synchroniser for a group of pins
// assumes each bit is an independent level from outside the clock domain

module sfpi_sync
	import sfpi_pkg::*;
#(
	parameter int WIDTH = 1 // number of independent levels
) (
	input  wire logic             clock,    // system clock
	input  wire logic             rst_n,    // synchronous reset, active low
	input  wire logic [WIDTH-1:0] async_in, // raw pin levels
	output logic      [WIDTH-1:0] sync_out  // levels safe to read
);

	// ****************************************************
	// elaboration check
	// ****************************************************
	if (WIDTH < 1) begin : g_bad_width
		$error("sfpi_sync needs at least one bit");
	end

	// ****************************************************
	// per-bit flop chains
	// ****************************************************
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic meta_ff; // first stage, read by the second stage only
		logic safe_ff; // second stage

		// two flops in a row per pin
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				meta_ff <= 1'b0;
				safe_ff <= 1'b0;
			end else begin
				meta_ff <= async_in[i];
				safe_ff <= meta_ff;
			end
		end

		assign sync_out[i] = safe_ff;
	end

endmodule : sfpi_sync

// ===== core/sfpi_core.sv
// holds the pin-level slave interface of a serial flash memory
// assumes the master's serial clock is slower than a quarter of clock
// and that command decoding, address map and array sit outside
//
// Summary of operation
// - launch output bits after serial clock falls
// - capture input bits on serial clock rise
// - select high: deselected, output lane floats
// - ignore commands until first select fall
// - pause low: float output, ignore inputs, stay selected
// - write protect low blocks protected program/erase
// - multi-lane modes turn data-out into input
// - multi-lane output phases drive data-in lane
// - quad mode drives pause and protect lanes
// - active when select low or write busy, else standby
// - clock modes zero and three, same edges
// - quad setting maps protect, pause onto lanes

module sfpi_core
	import sfpi_pkg::*;
(
	input  wire logic       clock,                     // system clock
	input  wire logic       rst_n,                     // synchronous reset
	input  wire logic       sck,                       // serial clock pin
	input  wire logic       cs_n,                      // select pin, active low
	input  wire logic       data_in_lane0,             // lane 0 pin level
	output logic            data_in_lane0_drv,         // lane 0 drive value
	output logic            data_in_lane0_en,          // lane 0 drive enable
	input  wire logic       data_out_lane1,            // lane 1 pin level
	output logic            data_out_lane1_drv,        // lane 1 drive value
	output logic            data_out_lane1_en,         // lane 1 drive enable
	input  wire logic       write_protect_n_lane2,     // lane 2 pin level
	output logic            write_protect_n_lane2_drv, // lane 2 drive value
	output logic            write_protect_n_lane2_en,  // lane 2 drive enable
	input  wire logic       pause_n_lane3,             // lane 3 pin level
	output logic            pause_n_lane3_drv,         // lane 3 drive value
	output logic            pause_n_lane3_en,          // lane 3 drive enable
	input  wire logic [1:0] io_width,                  // lanes in use now
	input  wire logic       out_phase,                 // device output phase
	output logic      [7:0] rx_byte,                   // last byte captured
	output logic            rx_valid,                  // rx_byte new, pulse
	input  wire logic [7:0] tx_byte,                   // next byte to send
	output logic            tx_take,                   // tx_byte taken, pulse
	input  wire logic       write_busy,                // program/erase pending
	input  wire logic       prog_req,                  // program/erase request
	input  wire logic       prog_area_hit,             // target in protect area
	output logic            prog_grant,                // request may alter data
	output logic            active_power,              // active power state
	output logic [BP_W-1:0] block_protect_field,       // protect area selector
	input  wire logic [3:0] reg_addr,                  // register address
	input  wire logic [7:0] reg_wdata,                 // register write data
	input  wire logic       reg_wr,                    // write strobe
	input  wire logic       reg_rd,                    // read strobe
	output logic      [7:0] reg_rdata                  // read data, next cycle
);

	// ****************************************************
	// helper functions
	// ****************************************************

	// bits moved per serial clock edge
	function automatic logic [2:0] lane_step(input sfpi_width_e w);
		case (w)
			SFPI_W2: lane_step = 3'h2;
			SFPI_W4: lane_step = 3'h4;
			default: lane_step = 3'h1;
		endcase
	endfunction : lane_step

	// shift a byte left by the lane count, filling from bits
	function automatic logic [7:0] shift_by(input logic [7:0] word,
		input logic [3:0] bits, input sfpi_width_e w);
		case (w)
			SFPI_W2: shift_by = {word[5:0], bits[1:0]};
			SFPI_W4: shift_by = {word[3:0], bits[3:0]};
			default: shift_by = {word[6:0], bits[0]};
		endcase
	endfunction : shift_by

	// lanes the device drives in an output phase
	function automatic logic [3:0] lane_mask(input sfpi_width_e w);
		case (w)
			SFPI_W2: lane_mask = 4'h3;
			SFPI_W4: lane_mask = 4'hF;
			default: lane_mask = 4'h2;
		endcase
	endfunction : lane_mask

	// ****************************************************
	// pin synchronisers
	// ****************************************************
	logic [PIN_COUNT-1:0] pin_raw; // raw pin levels
	logic [PIN_COUNT-1:0] pin_syn; // synchronised levels

	assign pin_raw = {sck, cs_n, write_protect_n_lane2, pause_n_lane3,
		data_out_lane1, data_in_lane0};

	sfpi_sync #(
		.WIDTH    (PIN_COUNT)
	) u_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in (pin_raw),
		.sync_out (pin_syn)
	);

	wire sck_s = pin_syn[5]; // serial clock
	wire cs_s  = pin_syn[4]; // select, high means deselected
	wire wp_s  = pin_syn[3]; // lane 2 level
	wire ps_s  = pin_syn[2]; // lane 3 level
	wire l1_s  = pin_syn[1]; // lane 1 level
	wire l0_s  = pin_syn[0]; // lane 0 level

	// ****************************************************
	// edge detection
	// ****************************************************
	logic sck_d_ff; // serial clock one cycle ago
	logic cs_d_ff;  // select one cycle ago

	// delayed copies for edge detection
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sck_d_ff <= 1'b0;
			cs_d_ff  <= 1'b0;
		end else begin
			sck_d_ff <= sck_s;
			cs_d_ff  <= cs_s;
		end
	end

	// idle level of the clock does not matter, only its edges
	wire sck_rise = sck_s & ~sck_d_ff;
	wire sck_fall = ~sck_s & sck_d_ff;
	wire cs_fall  = ~cs_s & cs_d_ff;   // select falling edge

	// ****************************************************
	// configuration and pin functions
	// ****************************************************
	logic [7:0]  cfg_ff;   // config register
	logic        armed_ff; // first select fall seen
	sfpi_link_e  state_ff; // link state
	sfpi_link_e  nxt_state;

	wire quad_en   = cfg_ff[CFG_QUAD_BIT];           // quad pin-out
	wire pause_act = ~quad_en & ~ps_s;
	wire wp_act    = ~quad_en & ~wp_s;
	wire armed_now = armed_ff | cs_fall;
	assign block_protect_field = cfg_ff[CFG_BP_LSB +: BP_W];

	// a quad width without the quad pin-out falls back to one lane
	sfpi_width_e eff_w; // width in effect
	assign eff_w = (io_width == SFPI_W2) ? SFPI_W2 :
		(io_width == SFPI_W4 && quad_en) ? SFPI_W4 : SFPI_W1;

	wire [2:0] step = lane_step(eff_w); // bits per edge

	// ****************************************************
	// link state machine
	// ****************************************************

	// next state from select and pause
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			LS_IDLE: begin
				if (!cs_s && armed_now) begin
					nxt_state = pause_act ? LS_PAUSE : LS_ACTIVE;
				end
			end
			LS_ACTIVE: begin
				if (cs_s) begin
					nxt_state = LS_IDLE;
				end else if (pause_act) begin
					nxt_state = LS_PAUSE;
				end
			end
			LS_PAUSE: begin
				if (cs_s) begin
					nxt_state = LS_IDLE;
				end else if (!pause_act) begin
					nxt_state = LS_ACTIVE;
				end
			end
			default: begin
				nxt_state = LS_IDLE;
			end
		endcase
	end

	// state and first-select latch
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_ff <= LS_IDLE;
			armed_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			armed_ff <= armed_now;
		end
	end

	// shifting stops at once on deselect or pause
	wire selected = (state_ff != LS_IDLE);
	wire shifting = (state_ff == LS_ACTIVE) & ~cs_s & ~pause_act;
	wire rise_in  = sck_rise & shifting & ~out_phase;
	wire fall_out = sck_fall & shifting & out_phase;

	// ****************************************************
	// receive path
	// ****************************************************
	logic [7:0] rx_sh_ff;   // partial input byte
	logic [2:0] rx_cnt_ff;  // bits gathered
	logic [7:0] rx_byte_ff; // finished byte
	logic       rx_vld_ff;  // finished byte pulse
	logic [3:0] in_bits;    // lane bits this edge
	logic [7:0] rx_next;    // shifted byte
	logic [2:0] rx_cnt_sum; // bit count after this edge

	// in multi-lane modes the data-out lane is read as input
	assign in_bits    = (eff_w == SFPI_W4) ? {ps_s, wp_s, l1_s, l0_s} :
		(eff_w == SFPI_W2) ? {2'b00, l1_s, l0_s} : {3'b000, l0_s};
	assign rx_next    = shift_by(rx_sh_ff, in_bits, eff_w);
	assign rx_cnt_sum = rx_cnt_ff + step;

	// gather bits on rising edges, count restarts each select
	always_ff @(posedge clock) begin
		if (!rst_n || !selected) begin
			rx_sh_ff  <= 8'h00;
			rx_cnt_ff <= 3'h0;
		end else if (rise_in) begin
			rx_sh_ff  <= rx_next;
			rx_cnt_ff <= rx_cnt_sum;
		end
	end

	// hand a finished byte on with a one-cycle pulse
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rx_byte_ff <= 8'h00;
			rx_vld_ff  <= 1'b0;
		end else begin
			rx_vld_ff <= rise_in && (rx_cnt_sum == 3'h0);
			if (rise_in && (rx_cnt_sum == 3'h0)) begin
				rx_byte_ff <= rx_next;
			end
		end
	end

	assign rx_byte  = rx_byte_ff;
	assign rx_valid = rx_vld_ff;

	// ****************************************************
	// transmit path
	// ****************************************************
	logic [7:0] tx_sh_ff;  // remaining output bits
	logic [2:0] tx_cnt_ff; // bits sent of this byte
	logic [3:0] drv_ff;    // lane drive values
	logic [3:0] oe_ff;     // lanes armed for output
	logic [7:0] tx_word;   // byte feeding this edge
	logic [3:0] tx_bits;   // lane values this edge
	logic [3:0] lane_en;   // final lane enables

	assign tx_word = (tx_cnt_ff == 3'h0) ? tx_byte : tx_sh_ff;
	assign tx_take = fall_out && (tx_cnt_ff == 3'h0);
	assign tx_bits = (eff_w == SFPI_W4) ? tx_word[7:4] :
		(eff_w == SFPI_W2) ? {2'b00, tx_word[7:6]} : {2'b00, tx_word[7], 1'b0};

	// launch the next bits after each falling edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tx_sh_ff  <= 8'h00;
			tx_cnt_ff <= 3'h0;
			drv_ff    <= 4'h0;
		end else if (!selected || !out_phase) begin
			tx_cnt_ff <= 3'h0;                        // next phase starts a byte
		end else if (fall_out) begin
			tx_sh_ff  <= shift_by(tx_word, 4'h0, eff_w);
			tx_cnt_ff <= tx_cnt_ff + step;
			drv_ff    <= tx_bits;
		end
	end

	// lanes turn on at the first launching edge of an output phase
	always_ff @(posedge clock) begin
		if (!rst_n || !selected || !out_phase) begin
			oe_ff <= 4'h0;
		end else if (fall_out) begin
			oe_ff <= lane_mask(eff_w);
		end
	end

	// enables drop the same cycle select, pause or phase go away
	assign lane_en = oe_ff & lane_mask(eff_w) &
		{4{shifting & out_phase}};

	assign data_in_lane0_drv         = drv_ff[0];
	assign data_in_lane0_en          = lane_en[0];
	assign data_out_lane1_drv        = drv_ff[1];
	assign data_out_lane1_en         = lane_en[1];
	assign write_protect_n_lane2_drv = drv_ff[2];
	assign write_protect_n_lane2_en  = lane_en[2];
	assign pause_n_lane3_drv         = drv_ff[3];
	assign pause_n_lane3_en          = lane_en[3];

	// ****************************************************
	// protection gate and power state
	// ****************************************************
	wire bp_any = |block_protect_field; // some area protected

	assign prog_grant   = prog_req & ~(wp_act & prog_area_hit & bp_any);
	assign active_power = ~cs_s | write_busy;

	// ****************************************************
	// register port
	// ****************************************************
	logic [7:0] rdata_ff; // read data, one cycle after the strobe
	logic [7:0] status;   // live status view
	logic [7:0] rd_mux;   // selected read value

	assign status = {3'b000, wp_act, (state_ff == LS_PAUSE), active_power,
		selected, armed_ff};
	assign rd_mux = (reg_addr == REG_CONFIG) ? cfg_ff :
		(reg_addr == REG_STATUS) ? status : 8'h00;

	// config writes and registered reads
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cfg_ff   <= CFG_RESET;
			rdata_ff <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == REG_CONFIG) begin
				cfg_ff <= {4'h0, reg_wdata[3:0]};
			end
			rdata_ff <= reg_rd ? rd_mux : 8'h00;
		end
	end

	assign reg_rdata = rdata_ff;

	// ****************************************************
	// assertions and covers
	// ****************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	a_out_on_fall: assert property (
		$changed(drv_ff) |-> $past(sck_fall) && $past(out_phase))
		else $error("lane value changed without a falling edge");

	a_in_on_rise: assert property (
		rx_valid |-> $past(sck_rise) && !$past(out_phase) && $past(armed_now))
		else $error("byte finished without a rising edge");

	a_deselect_float: assert property (
		cs_s |-> (lane_en == 4'h0) ##1 (state_ff == LS_IDLE))
		else $error("lane driven or state kept while deselected");

	a_first_select: assert property (
		!armed_ff |-> (state_ff == LS_IDLE) && !rx_valid)
		else $error("device left idle before first select fall");

	a_pause_float: assert property (
		(state_ff == LS_PAUSE) |-> (lane_en == 4'h0) && $stable(rx_cnt_ff)
			&& selected)
		else $error("activity while paused");

	a_protect_gate: assert property (
		(wp_act && prog_area_hit && bp_any) |-> !prog_grant)
		else $error("protected area left open");

	a_lane1_input: assert property (
		(eff_w != SFPI_W1 && !out_phase) |-> !data_out_lane1_en)
		else $error("data-out lane driven in input phase");

	a_lane0_drive: assert property (
		data_in_lane0_en |-> (eff_w != SFPI_W1) && out_phase
			&& $past(out_phase))
		else $error("data-in lane driven outside multi-lane output");

	a_quad_lanes: assert property (
		(|lane_en[3:2]) |-> quad_en && (eff_w == SFPI_W4))
		else $error("upper lanes driven outside quad output");

	a_power_state: assert property (
		$fell(cs_s) |-> active_power ##1 (state_ff != LS_IDLE || !armed_now))
		else $error("select fall did not give active power");

	a_quad_no_pause: assert property (
		(quad_en && $past(quad_en)) |-> (state_ff != LS_PAUSE) && !wp_act)
		else $error("pin function alive in quad pin-out");

	a_idle_release: assert property (
		!out_phase |=> !out_phase |-> (oe_ff == 4'h0) && (lane_en == 4'h0))
		else $error("lane left driven outside output phase");

	c_byte_in: cover property (rx_valid && eff_w == SFPI_W1);
	c_quad_out: cover property (tx_take && eff_w == SFPI_W4);
	c_pause_resume: cover property ((state_ff == LS_PAUSE) ##1
		(state_ff == LS_ACTIVE));
	c_wp_block: cover property (prog_req && !prog_grant);

endmodule : sfpi_core

// ===== testbench/sfpi_master.sv
// holds a behavioural bus master that drives the flash pins
// assumes the bench resolves each lane from both parties' enables
module sfpi_master (
	output logic            sck,   // serial clock
	output logic            cs_n,  // select, active low
	output logic      [3:0] m_val, // lane drive values
	output logic      [3:0] m_en,  // lane drive enables
	input  wire logic [3:0] lanes  // resolved lane levels
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam realtime HALF = 62.5; // half of the 125 ns link period
	logic idle_hi;                   // high selects clock mode three

	// ****
	// idle: deselected, pause and protect held high
	// ****
	initial begin
		idle_hi = 1'b0;
		sck     = 1'b0;
		cs_n    = 1'b1;
		m_val   = 4'hF;
		m_en    = 4'hC;
	end

	// select edge comes before any command, clock parked at mode idle
	task automatic select();
		sck = idle_hi;
		#HALF;
		cs_n = 1'b0;
		#HALF;
	endtask : select

	// park the clock, then raise select and restore the idle pins
	task automatic deselect();
		#HALF;
		sck = idle_hi;
		#HALF;
		cs_n  = 1'b1;
		m_en  = 4'hC;
		m_val = 4'hF;
		#HALF;
	endtask : deselect

	// pause and protect levels; select is left as it is
	task automatic set_pin(input int i, input logic v);
		m_val[i] = v;
		m_en[i]  = 1'b1;
	endtask : set_pin

	// n clock periods of w lanes: data set while low, sampled at the rise
	task automatic shift(input int w, input int n, input logic [7:0] din,
		input bit drv, output logic [7:0] dout);
		logic [3:0] mask;
		logic [3:0] omask;
		logic [7:0] t;
		mask  = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hF;
		omask = (w == 1) ? 4'h2 : mask;
		dout  = 8'h00;
		m_en  = drv ? (m_en | mask) : (m_en & ~omask);
		for (int i = 0; i < n; i++) begin
			sck = 1'b0;
			t   = din << (i * w);
			if (drv) begin
				m_val = (m_val & ~mask) | (4'(t >> (8 - w)) & mask);
			end
			#HALF;
			sck  = 1'b1;
			dout = (dout << w) | 8'((w == 1) ? 4'(lanes[1]) : (lanes & mask));
			#HALF;
		end
	endtask : shift
endmodule : sfpi_master

// ===== testbench/sfpi_core_tb_top.sv
// holds the self-checking bench of the pin interface
// assumes sfpi_master on the pins and pull-ups on every lane
module sfpi_core_tb_top
	import sfpi_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic            clock, rst_n, out_phase, write_busy, prog_req, prog_area_hit;
	logic            reg_wr, reg_rd, rx_valid, tx_take, prog_grant, active_power;
	logic      [1:0] io_width;
	logic      [3:0] reg_addr;
	logic      [7:0] tx_byte, reg_wdata, rx_byte, reg_rdata, rx_last, rx_cnt, got, n0, n_tx;
	logic [BP_W-1:0] block_protect_field;
	logic            data_in_lane0_drv, data_out_lane1_drv;
	logic            write_protect_n_lane2_drv, pause_n_lane3_drv;
	logic            data_in_lane0_en, data_out_lane1_en;
	logic            write_protect_n_lane2_en, pause_n_lane3_en;
	wire logic       sck, cs_n, data_in_lane0, data_out_lane1;
	wire logic       write_protect_n_lane2, pause_n_lane3;
	wire logic [3:0] m_val, m_en, lanes, dut_en;
	int              fails, n_checks, cyc;

	// ****
	// pins: device drive wins, then master, else pull-up
	// ****
	assign dut_en = {pause_n_lane3_en, write_protect_n_lane2_en, data_out_lane1_en,
		data_in_lane0_en};
	assign data_in_lane0 = data_in_lane0_en ? data_in_lane0_drv : m_en[0] ? m_val[0] : 1'b1;
	assign data_out_lane1 = data_out_lane1_en ? data_out_lane1_drv : m_en[1] ? m_val[1] : 1'b1;
	assign write_protect_n_lane2 = write_protect_n_lane2_en ? write_protect_n_lane2_drv :
		m_en[2] ? m_val[2] : 1'b1;
	assign pause_n_lane3 = pause_n_lane3_en ? pause_n_lane3_drv : m_en[3] ? m_val[3] : 1'b1;
	assign lanes = {pause_n_lane3, write_protect_n_lane2, data_out_lane1, data_in_lane0};

	sfpi_core dut (.clock, .rst_n, .sck, .cs_n, .data_in_lane0, .data_in_lane0_drv,
		.data_in_lane0_en, .data_out_lane1, .data_out_lane1_drv, .data_out_lane1_en,
		.write_protect_n_lane2, .write_protect_n_lane2_drv, .write_protect_n_lane2_en,
		.pause_n_lane3, .pause_n_lane3_drv, .pause_n_lane3_en, .io_width, .out_phase,
		.rx_byte, .rx_valid, .tx_byte, .tx_take, .write_busy, .prog_req, .prog_area_hit,
		.prog_grant, .active_power, .block_protect_field, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata);
	sfpi_master m (.sck, .cs_n, .m_val, .m_en, .lanes);

	// clock at 100 MHz
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ****
	// monitors: received bytes, taken send bytes and hang limit
	// ****
	always @(posedge clock) begin
		if (rx_valid === 1'b1) begin
			rx_last <= rx_byte;
			rx_cnt  <= rx_cnt + 8'h01;
		end
		if (tx_take === 1'b1) begin
			n_tx <= n_tx + 8'h01;
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			wrap_up();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		if (fails == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	// ****
	// register port and pin helpers
	// ****
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : reg_read

	// lets pin changes pass the synchroniser
	task automatic settle();
		repeat (6) @(posedge clock);
		#1;
	endtask : settle

	task automatic byte_in(input int w, input logic [7:0] d);
		n0 = rx_cnt;
		m.shift(w, 8 / w, d, 1'b1, got);
		settle();
		check(rx_cnt, n0 + 8'h01);
		check(rx_last, d);
	endtask : byte_in

	task automatic byte_out(input int w, input logic [7:0] d, input logic [3:0] en);
		@(posedge clock);
		out_phase <= 1'b1;
		tx_byte   <= d;
		n0 = n_tx;
		m.shift(w, 8 / w, 8'h00, 1'b0, got);
		check(got, d);
		check(n_tx, n0 + 8'h01);
		check({4'h0, dut_en}, {4'h0, en});
		m.deselect();
		settle();
		check({4'h0, dut_en}, 8'h00);
		@(posedge clock);
		out_phase <= 1'b0;
	endtask : byte_out

	// ****
	// scenarios
	// ****
	task automatic t_regs();
		check({4'h0, dut_en}, 8'h00);
		// select high must pass the synchroniser before status reads idle
		settle();
		reg_read(REG_STATUS, got);
		check(got, 8'h00);
		reg_write(REG_CONFIG, 8'hFF);
		reg_read(REG_CONFIG, got);
		check(got, 8'h0F);
		reg_write(4'h7, 8'hFF);
		reg_read(4'h7, got);
		check(got, 8'h00);
		reg_write(REG_CONFIG, 8'h00);
	endtask : t_regs

	// select held low through a reset gives no edge: bytes refused
	task automatic t_arming();
		m.select();
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		n0 = rx_cnt;
		m.shift(1, 8, 8'hC3, 1'b1, got);
		settle();
		check(rx_cnt, n0);
		reg_read(REG_STATUS, got);
		check(got, 8'h04);
		m.deselect();
		m.select();
		byte_in(1, 8'h81);
		byte_in(1, 8'h5A);
		byte_out(1, 8'hA5, 4'h2);
	endtask : t_arming

	// garbage clocked during a pause must not enter the byte
	task automatic t_pause();
		m.select();
		n0 = rx_cnt;
		m.shift(1, 4, 8'hB7, 1'b1, got);
		m.set_pin(3, 1'b0);
		settle();
		reg_read(REG_STATUS, got);
		check(got, 8'h0F);
		m.shift(1, 4, 8'h00, 1'b1, got);
		m.set_pin(3, 1'b1);
		settle();
		m.shift(1, 4, 8'h70, 1'b1, got);
		settle();
		check(rx_cnt, n0 + 8'h01);
		check(rx_last, 8'hB7);
		m.deselect();
	endtask : t_pause

	// each entry: config, protect pin, area hit, expected grant
	task automatic t_protect();
		logic [10:0] tbl [5] = '{{8'h06, 3'b010}, {8'h06, 3'b001}, {8'h06, 3'b111},
			{8'h00, 3'b011}, {8'h07, 3'b011}};
		prog_req <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			reg_write(REG_CONFIG, tbl[i][10:3]);
			m.set_pin(2, tbl[i][2]);
			prog_area_hit <= tbl[i][1];
			settle();
			check({7'h00, prog_grant}, {7'h00, tbl[i][0]});
		end
		check({5'h00, block_protect_field}, 8'h03);
		reg_write(REG_CONFIG, 8'h00);
		m.set_pin(2, 1'b1);
		prog_req <= 1'b0;
	endtask : t_protect

	task automatic t_power();
		write_busy <= 1'b1;
		settle();
		check({7'h00, active_power}, 8'h01);
		@(posedge clock) write_busy <= 1'b0;
		settle();
		check({7'h00, active_power}, 8'h00);
		m.select();
		settle();
		check({7'h00, active_power}, 8'h01);
		m.deselect();
	endtask : t_power

	// dual, clock mode three, then quad lanes
	task automatic t_lanes();
		m.select();
		@(posedge clock) io_width <= 2'd1;
		byte_in(2, 8'h96);
		byte_out(2, 8'h3C, 4'h3);
		m.idle_hi = 1'b1;
		m.select();
		@(posedge clock) io_width <= 2'd0;
		byte_in(1, 8'h3E);
		byte_out(1, 8'hD2, 4'h2);
		m.idle_hi = 1'b0;
		reg_write(REG_CONFIG, 8'h01);
		m.select();
		@(posedge clock) io_width <= 2'd2;
		byte_in(4, 8'h5A);
		byte_out(4, 8'hC3, 4'hF);
	endtask : t_lanes

	initial begin
		{rst_n, out_phase, write_busy, prog_req, prog_area_hit, reg_wr, reg_rd} = 7'h00;
		{io_width, reg_addr, tx_byte, reg_wdata} = 22'h000000;
		{rx_last, rx_cnt, n_tx} = 24'h000000;
		{fails, n_checks, cyc} = {32'd0, 32'd0, 32'd0};
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_arming();
		t_pause();
		t_protect();
		t_power();
		t_lanes();
		wrap_up();
	end
endmodule : sfpi_core_tb_top
